// [shared/sdc_pkg.sv]
package sdc_pkg;
    localparam int INSTR_W = 48;
    localparam int DATA_W = 32;
    localparam int EXT_W = 40;
    localparam int ADDR_W = 32;
    localparam int REG_CNT = 16;
    localparam int REG_IDX_W = 4;
    localparam int CIRC_SETS = 16;
    localparam int CACHE_DEPTH = 32;
    localparam int CACHE_IDX_W = 5;
    // instruction field positions
    localparam int F_COND_EN = 47;
    localparam int F_COND_FLAG = 46;
    localparam int F_FMT_HI = 45;
    localparam int F_FMT_LO = 44;
    localparam int F_ALU_HI = 43;
    localparam int F_ALU_LO = 41;
    localparam int F_MUL_EN = 40;
    localparam int F_SHF_HI = 39;
    localparam int F_SHF_LO = 38;
    localparam int F_DST_HI = 37;
    localparam int F_DST_LO = 34;
    localparam int F_SRCX_HI = 33;
    localparam int F_SRCX_LO = 30;
    localparam int F_SRCY_HI = 29;
    localparam int F_SRCY_LO = 26;
    localparam int F_MDST_HI = 25;
    localparam int F_MDST_LO = 22;
    localparam int F_DM_EN = 21;
    localparam int F_DM_WR = 20;
    localparam int F_DM_REG_HI = 19;
    localparam int F_DM_REG_LO = 16;
    localparam int F_DM_SET_HI = 15;
    localparam int F_DM_SET_LO = 12;
    localparam int F_PM_EN = 11;
    localparam int F_PM_WR = 10;
    localparam int F_PM_REG_HI = 9;
    localparam int F_PM_REG_LO = 6;
    localparam int F_PM_SET_HI = 5;
    localparam int F_PM_SET_LO = 2;
    // core mode control bit positions
    localparam int MODE_W = 4;
    localparam int MODE_SECOND_EN = 0;
    localparam int MODE_REG_ALT = 1;
    localparam int MODE_DAG1_ALT = 2;
    localparam int MODE_DAG2_ALT = 3;
    localparam logic [3:0] MODE_RESET = 4'h0;

    typedef enum logic [1:0] {
        FMT_FIXED = 2'b00,
        FMT_SINGLE = 2'b01,
        FMT_EXTENDED = 2'b10,
        FMT_RSVD = 2'b11
    } sdc_fmt_e;

    typedef enum logic [2:0] {
        ALU_NOP = 3'b000,
        ALU_ADD = 3'b001,
        ALU_SUB = 3'b010,
        ALU_ADDSUB = 3'b011,
        ALU_AND = 3'b100,
        ALU_OR = 3'b101,
        ALU_XOR = 3'b110,
        ALU_PASS = 3'b111
    } sdc_alu_e;

    typedef enum logic [1:0] {
        SHF_NOP = 2'b00,
        SHF_LSL = 2'b01,
        SHF_LSR = 2'b10,
        SHF_ASR = 2'b11
    } sdc_shf_e;
endpackage

// [hdl/sdc_core.sv]
// Overview of operation
// RULE1 - first element always on, second by enable
// RULE2 - same instruction in both elements, own data
// RULE3 - simd access moves one word per element
// RULE4 - alu, multiplier, shifter parallel, single cycle
// RULE5 - multifunction alu plus multiply in both
// RULE6 - fixed, single and extended formats
// RULE7 - 32 registers per element, two banks
// RULE8 - separate register name sets per element
// RULE9 - data bus data only, program bus both
// RULE10 - four operands plus cached instruction per cycle
// RULE11 - four 32-bit transfers each cycle
// RULE12 - cache only instructions that conflicted
// RULE13 - 32 circular buffer sets, two groups
// RULE14 - automatic pointer wrap, any location
// RULE15 - 48-bit conditional multifunction instruction
// RULE16 - mode bits select banks without corruption
module sdc_core
    import sdc_pkg::*;
#(
    parameter int CACHE_DEPTH_P = sdc_pkg::CACHE_DEPTH
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [sdc_pkg::MODE_W-1:0] core_mode_control_i,
    input wire logic [sdc_pkg::ADDR_W-1:0] fetch_addr_i,
    input wire logic fetch_valid_i,
    output logic fetch_stall_o,
    output logic [sdc_pkg::ADDR_W-1:0] pm_instr_addr_o,
    output logic pm_instr_req_o,
    input wire logic [sdc_pkg::INSTR_W-1:0] pm_instr_i,
    output logic [sdc_pkg::ADDR_W-1:0] dm_addr_o,
    output logic dm_req_o,
    output logic dm_we_o,
    output logic [sdc_pkg::DATA_W-1:0] dm_wdata_x_o,
    output logic [sdc_pkg::DATA_W-1:0] dm_wdata_y_o,
    input wire logic [sdc_pkg::DATA_W-1:0] dm_rdata_x_i,
    input wire logic [sdc_pkg::DATA_W-1:0] dm_rdata_y_i,
    output logic [sdc_pkg::ADDR_W-1:0] pm_data_addr_o,
    output logic pm_data_req_o,
    output logic pm_data_we_o,
    output logic [sdc_pkg::DATA_W-1:0] pm_wdata_x_o,
    output logic [sdc_pkg::DATA_W-1:0] pm_wdata_y_o,
    input wire logic [sdc_pkg::DATA_W-1:0] pm_rdata_x_i,
    input wire logic [sdc_pkg::DATA_W-1:0] pm_rdata_y_i,
    input wire logic dag_load_i,
    input wire logic dag_sel_i,
    input wire logic [3:0] dag_set_i,
    input wire logic [sdc_pkg::ADDR_W-1:0] dag_base_i,
    input wire logic [sdc_pkg::ADDR_W-1:0] dag_len_i,
    input wire logic [sdc_pkg::ADDR_W-1:0] dag_step_i,
    input wire logic cond_flag_i,
    output logic [sdc_pkg::EXT_W-1:0] result_x_o,
    output logic [sdc_pkg::EXT_W-1:0] result_y_o,
    output logic result_valid_o
);
    import sdc_pkg::*;

    // banks stored flat: index = bank*16 + reg; the idle bank is never written
    logic [EXT_W-1:0] rf_x_q [2*REG_CNT]; // RULE7 RULE8
    logic [EXT_W-1:0] rf_y_q [2*REG_CNT]; // RULE7 RULE8
    logic [ADDR_W-1:0] ptr_q [2][2*CIRC_SETS]; // RULE13
    logic [ADDR_W-1:0] base_q [2][2*CIRC_SETS];
    logic [ADDR_W-1:0] len_q [2][2*CIRC_SETS];
    logic [ADDR_W-1:0] step_q [2][2*CIRC_SETS];
    logic [INSTR_W-1:0] cache_data_q [CACHE_DEPTH_P];
    logic [ADDR_W-1:0] cache_tag_q [CACHE_DEPTH_P];
    logic [CACHE_DEPTH_P-1:0] cache_vld_q;
    logic [CACHE_IDX_W-1:0] cidx;
    logic cache_hit, pm_conflict_q, exec;
    logic [INSTR_W-1:0] instr;
    logic second_en, reg_alt;
    logic [4:0] dag_set_idx [2];
    logic [4:0] ld_idx;

    function automatic logic [ADDR_W-1:0] circ_next(input logic [ADDR_W-1:0] p, input logic [ADDR_W-1:0] b,
                                                     input logic [ADDR_W-1:0] l, input logic [ADDR_W-1:0] s);
        logic [ADDR_W-1:0] n;
        n = p + s;
        if (n >= b + l) // RULE14
            n = n - l;
        return n;
    endfunction

    function automatic logic [EXT_W-1:0] fmt_mask(input logic [1:0] f);
        return (f == FMT_EXTENDED) ? {EXT_W{1'b1}} : {{(EXT_W-DATA_W){1'b0}}, {DATA_W{1'b1}}}; // RULE6
    endfunction

    function automatic logic [EXT_W-1:0] alu_op(input logic [2:0] op, input logic [1:0] fmt,
                                                input logic [EXT_W-1:0] a, input logic [EXT_W-1:0] b);
        logic [EXT_W-1:0] r;
        logic [EXT_W-1:0] m;
        m = fmt_mask(fmt); // RULE6
        case (op)
            ALU_ADD: r = a + b;
            ALU_SUB: r = a - b;
            ALU_ADDSUB: r = a + b;
            ALU_AND: r = a & b;
            ALU_OR: r = a | b;
            ALU_XOR: r = a ^ b;
            ALU_PASS: r = a;
            default: r = '0;
        endcase
        return r & m;
    endfunction

    function automatic logic [EXT_W-1:0] shf_op(input logic [1:0] op, input logic [EXT_W-1:0] a,
                                                input logic [EXT_W-1:0] b);
        logic [EXT_W-1:0] r;
        case (op)
            SHF_LSL: r = a << b[4:0];
            SHF_LSR: r = a >> b[4:0];
            SHF_ASR: r = EXT_W'($signed(a) >>> b[4:0]);
            default: r = a;
        endcase
        return r;
    endfunction

    assign second_en = core_mode_control_i[MODE_SECOND_EN]; // RULE1
    assign reg_alt = core_mode_control_i[MODE_REG_ALT]; // RULE16

    // instruction cache: direct mapped, filled only on program bus conflict
    assign cidx = fetch_addr_i[CACHE_IDX_W-1:0];
    assign cache_hit = cache_vld_q[cidx] && cache_tag_q[cidx] == fetch_addr_i;
    // a conflicting fetch that misses costs one stall cycle while the bus is shared
    assign fetch_stall_o = fetch_valid_i && pm_conflict_q && !cache_hit; // RULE12
    assign pm_instr_req_o = fetch_valid_i && !cache_hit; // RULE9
    assign pm_instr_addr_o = fetch_addr_i;
    assign instr = cache_hit ? cache_data_q[cidx] : pm_instr_i; // RULE10
    assign exec = fetch_valid_i && !fetch_stall_o;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cache_vld_q <= '0;
        else if (fetch_valid_i && pm_conflict_q && !cache_hit)
            cache_vld_q[cidx] <= 1'b1; // RULE12
    end

    always_ff @(posedge clk_i)
    begin
        if (fetch_valid_i && pm_conflict_q && !cache_hit)
        begin
            cache_data_q[cidx] <= pm_instr_i; // RULE12
            cache_tag_q[cidx] <= fetch_addr_i;
        end
    end

    // decode
    logic cond_ok;
    logic [1:0] fmt;
    logic [3:0] dst, srcx, srcy, mdst, dm_reg, pm_reg;
    logic [4:0] bk;
    assign cond_ok = !instr[F_COND_EN] || (instr[F_COND_FLAG] == cond_flag_i); // RULE15
    assign fmt = instr[F_FMT_HI:F_FMT_LO];
    assign dst = instr[F_DST_HI:F_DST_LO];
    assign srcx = instr[F_SRCX_HI:F_SRCX_LO];
    assign srcy = instr[F_SRCY_HI:F_SRCY_LO];
    assign mdst = instr[F_MDST_HI:F_MDST_LO];
    assign dm_reg = instr[F_DM_REG_HI:F_DM_REG_LO];
    assign pm_reg = instr[F_PM_REG_HI:F_PM_REG_LO];
    assign bk = {reg_alt, 4'h0};

    logic go;
    assign go = exec && cond_ok;

    // per-element compute: alu, multiplier, shifter in parallel, one cycle
    logic [EXT_W-1:0] ax, bx, ay, by, alu_x, alu_y, mul_x, mul_y, shf_x, shf_y;
    assign ax = rf_x_q[bk + 5'(srcx)];
    assign bx = rf_x_q[bk + 5'(srcy)];
    assign ay = rf_y_q[bk + 5'(srcx)]; // RULE2
    assign by = rf_y_q[bk + 5'(srcy)];
    assign alu_x = alu_op(instr[F_ALU_HI:F_ALU_LO], fmt, ax, bx); // RULE4
    assign alu_y = alu_op(instr[F_ALU_HI:F_ALU_LO], fmt, ay, by);
    // every unit is cut to the format width, so fixed results never carry into bits 39:32
    assign mul_x = EXT_W'(ax * bx) & fmt_mask(fmt); // RULE5 RULE6
    assign mul_y = EXT_W'(ay * by) & fmt_mask(fmt);
    assign shf_x = shf_op(instr[F_SHF_HI:F_SHF_LO], ax, bx) & fmt_mask(fmt);
    assign shf_y = shf_op(instr[F_SHF_HI:F_SHF_LO], ay, by) & fmt_mask(fmt);

    logic alu_act, shf_act;
    assign alu_act = instr[F_ALU_HI:F_ALU_LO] != ALU_NOP;
    assign shf_act = instr[F_SHF_HI:F_SHF_LO] != SHF_NOP;

    // address generators
    always_comb
    begin
        dag_set_idx[0] = {core_mode_control_i[MODE_DAG1_ALT], instr[F_DM_SET_HI:F_DM_SET_LO]}; // RULE16
        dag_set_idx[1] = {core_mode_control_i[MODE_DAG2_ALT], instr[F_PM_SET_HI:F_PM_SET_LO]};
    end
    assign ld_idx = {core_mode_control_i[dag_sel_i ? MODE_DAG2_ALT : MODE_DAG1_ALT], dag_set_i};

    logic dm_go, pm_go;
    assign dm_go = go && instr[F_DM_EN];
    assign pm_go = go && instr[F_PM_EN];

    // a program bus data access stalls the next fetch if that fetch misses the cache, wherever the accessing instruction came from
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            pm_conflict_q <= 1'b0;
        else
            pm_conflict_q <= pm_go; // RULE12
    end

    always_ff @(posedge clk_i)
    begin
        if (dag_load_i)
        begin
            base_q[dag_sel_i][ld_idx] <= dag_base_i;
            len_q[dag_sel_i][ld_idx] <= dag_len_i;
            step_q[dag_sel_i][ld_idx] <= dag_step_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (dag_load_i)
            ptr_q[dag_sel_i][ld_idx] <= dag_base_i;
        else
        begin
            if (dm_go) // RULE14
                ptr_q[0][dag_set_idx[0]] <= circ_next(ptr_q[0][dag_set_idx[0]], base_q[0][dag_set_idx[0]],
                                                     len_q[0][dag_set_idx[0]], step_q[0][dag_set_idx[0]]);
            if (pm_go)
                ptr_q[1][dag_set_idx[1]] <= circ_next(ptr_q[1][dag_set_idx[1]], base_q[1][dag_set_idx[1]],
                                                     len_q[1][dag_set_idx[1]], step_q[1][dag_set_idx[1]]);
        end
    end

    // both buses move two words per access in simd, one otherwise
    assign dm_req_o = dm_go; // RULE9 RULE11
    assign dm_we_o = dm_go && instr[F_DM_WR];
    assign dm_addr_o = ptr_q[0][dag_set_idx[0]];
    assign dm_wdata_x_o = rf_x_q[bk + 5'(dm_reg)][DATA_W-1:0];
    assign dm_wdata_y_o = second_en ? rf_y_q[bk + 5'(dm_reg)][DATA_W-1:0] : '0; // RULE3
    assign pm_data_req_o = pm_go; // RULE10
    assign pm_data_we_o = pm_go && instr[F_PM_WR];
    assign pm_data_addr_o = ptr_q[1][dag_set_idx[1]];
    assign pm_wdata_x_o = rf_x_q[bk + 5'(pm_reg)][DATA_W-1:0];
    assign pm_wdata_y_o = second_en ? rf_y_q[bk + 5'(pm_reg)][DATA_W-1:0] : '0; // RULE3

    // register file write-back; only the selected bank is touched
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < 2*REG_CNT; i++)
                rf_x_q[i] <= '0;
        end
        else if (go)
        begin
            if (alu_act)
                rf_x_q[bk + 5'(dst)] <= alu_x;
            else if (shf_act)
                rf_x_q[bk + 5'(dst)] <= shf_x;
            if (instr[F_MUL_EN]) // RULE5
                rf_x_q[bk + 5'(mdst)] <= mul_x;
            if (dm_go && !instr[F_DM_WR])
                rf_x_q[bk + 5'(dm_reg)] <= {{(EXT_W-DATA_W){1'b0}}, dm_rdata_x_i};
            if (pm_go && !instr[F_PM_WR])
                rf_x_q[bk + 5'(pm_reg)] <= {{(EXT_W-DATA_W){1'b0}}, pm_rdata_x_i};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < 2*REG_CNT; i++)
                rf_y_q[i] <= '0;
        end
        else if (go && second_en) // RULE1 RULE2
        begin
            if (alu_act)
                rf_y_q[bk + 5'(dst)] <= alu_y;
            else if (shf_act)
                rf_y_q[bk + 5'(dst)] <= shf_y;
            if (instr[F_MUL_EN])
                rf_y_q[bk + 5'(mdst)] <= mul_y;
            if (dm_go && !instr[F_DM_WR]) // RULE3
                rf_y_q[bk + 5'(dm_reg)] <= {{(EXT_W-DATA_W){1'b0}}, dm_rdata_y_i};
            if (pm_go && !instr[F_PM_WR])
                rf_y_q[bk + 5'(pm_reg)] <= {{(EXT_W-DATA_W){1'b0}}, pm_rdata_y_i};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            result_x_o <= '0;
            result_y_o <= '0;
            result_valid_o <= 1'b0;
        end
        else
        begin
            result_valid_o <= go;
            if (go)
            begin
                result_x_o <= alu_act ? alu_x : shf_x; // RULE4
                result_y_o <= second_en ? (alu_act ? alu_y : shf_y) : '0;
            end
        end
    end

    second_idle_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
        !second_en |=> $stable(rf_y_q[0]) || $past(reset_i))
        else $error("second element register changed while disabled");
    result_one_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
        go && alu_act |=> result_valid_o && result_x_o == $past(alu_x))
        else $error("alu result not delivered next cycle");
    simd_pair_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
        go && second_en && alu_act |=> result_y_o == $past(alu_y))
        else $error("second element did not execute");
    stall_cache_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE12
        fetch_stall_o |=> cache_vld_q[$past(cidx)])
        else $error("conflicting fetch not cached");
    no_pm_fetch_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
        cache_hit |-> !pm_instr_req_o)
        else $error("program bus fetch on cache hit");
    cond_skip_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE15
        exec && !cond_ok |-> !dm_req_o && !pm_data_req_o)
        else $error("memory access despite false condition");
    wrap_in_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE14
        dm_go && !dag_load_i && step_q[0][dag_set_idx[0]] < len_q[0][dag_set_idx[0]]
        && dm_addr_o >= base_q[0][dag_set_idx[0]] && dm_addr_o < base_q[0][dag_set_idx[0]] + len_q[0][dag_set_idx[0]]
        |=> ptr_q[0][$past(dag_set_idx[0])] < $past(base_q[0][dag_set_idx[0]] + len_q[0][dag_set_idx[0]]))
        else $error("circular pointer left buffer");
    dm_ydata_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
        !second_en |-> dm_wdata_y_o == '0 && pm_wdata_y_o == '0)
        else $error("second word driven while simd off");
endmodule

// [test/sdc_mem_model.sv]
module sdc_mem_model
    import sdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic [sdc_pkg::ADDR_W-1:0] ia_i,
    input wire logic ireq_i,
    output logic [sdc_pkg::INSTR_W-1:0] instr_o,
    input wire logic [sdc_pkg::ADDR_W-1:0] da_i,
    input wire logic dreq_i,
    input wire logic dwe_i,
    input wire logic [63:0] dw_i,
    output logic [63:0] dr_o,
    input wire logic [sdc_pkg::ADDR_W-1:0] pa_i,
    input wire logic preq_i,
    input wire logic pwe_i,
    input wire logic [63:0] pw_i,
    output logic [63:0] pr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] dm[256];
    logic [63:0] pm[256];
    logic [47:0] im[256];
    logic [31:0] cnt_q = 32'h0;
    // released buses show a moving pattern so stale data cannot pass for a read
    assign instr_o = ireq_i ? im[ia_i[7:0]] : {cnt_q[15:0], ~cnt_q};
    assign dr_o = (dreq_i && !dwe_i) ? dm[da_i[7:0]] : {cnt_q, ~cnt_q};
    assign pr_o = (preq_i && !pwe_i) ? pm[pa_i[7:0]] : {~cnt_q, cnt_q};
    always @(posedge clk_i)
    begin
        cnt_q <= cnt_q + 32'h1;
        if (dreq_i && dwe_i)
            dm[da_i[7:0]] <= dw_i;
        if (preq_i && pwe_i)
            pm[pa_i[7:0]] <= pw_i;
    end
endmodule

// [test/sdc_core_tb_top.sv]
module sdc_core_tb_top
    import sdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0;
    logic rst = 1;
    logic fv, stl, ir, dr, dw, pr, pw, dl, dsel, cf, ncf, rv, ppm;
    logic [3:0] mode, dset;
    logic [31:0] fa, ia, da, pa, db, dln, dst, seed;
    wire [63:0] dwd, pwd;
    logic [63:0] drd, prd;
    logic [47:0] ins;
    logic [39:0] rxo, ryo, lx;
    logic [39:0] rx[2][16];
    logic [39:0] ry[2][16];
    logic [31:0] bs[2][2][16], ln[2][2][16], sp[2][2][16], pt[2][2][16], ct[32];
    logic cv[32];
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int pc = 0;

    always #25 clk = ~clk;

    sdc_core sdc_core_i (.clk_i(clk), .reset_i(rst), .core_mode_control_i(mode), .fetch_addr_i(fa),
        .fetch_valid_i(fv), .fetch_stall_o(stl), .pm_instr_addr_o(ia), .pm_instr_req_o(ir), .pm_instr_i(ins),
        .dm_addr_o(da), .dm_req_o(dr), .dm_we_o(dw), .dm_wdata_x_o(dwd[31:0]), .dm_wdata_y_o(dwd[63:32]),
        .dm_rdata_x_i(drd[31:0]), .dm_rdata_y_i(drd[63:32]), .pm_data_addr_o(pa), .pm_data_req_o(pr),
        .pm_data_we_o(pw), .pm_wdata_x_o(pwd[31:0]), .pm_wdata_y_o(pwd[63:32]), .pm_rdata_x_i(prd[31:0]),
        .pm_rdata_y_i(prd[63:32]), .dag_load_i(dl), .dag_sel_i(dsel), .dag_set_i(dset), .dag_base_i(db),
        .dag_len_i(dln), .dag_step_i(dst), .cond_flag_i(cf), .result_x_o(rxo), .result_y_o(ryo),
        .result_valid_o(rv));
    sdc_mem_model sdc_mem_model_i (.clk_i(clk), .ia_i(ia), .ireq_i(ir), .instr_o(ins), .da_i(da), .dreq_i(dr),
        .dwe_i(dw), .dw_i(dwd), .dr_o(drd), .pa_i(pa), .preq_i(pr), .pwe_i(pw), .pw_i(pwd), .pr_o(prd));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp_bus(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp_res(input logic [39:0] g, input logic [39:0] e);
        cmp_bus(64'(g), 64'(e));
    endtask

    function automatic logic [47:0] op(input logic [2:0] a, input logic [1:0] f, input logic [3:0] d, x, y);
        return {2'b00, f, a, 3'b000, d, x, y, 26'h0};
    endfunction

    // each field is {enable, write, register, set}
    function automatic logic [47:0] mm(input logic [9:0] d, input logic [9:0] p);
        return {26'h0, d, p, 2'b00};
    endfunction

    // the nop code stands in for the multiplier here
    function automatic logic [39:0] alu(input logic [2:0] o, input logic [1:0] f, input logic [39:0] a, b);
        logic [39:0] r;
        case (o)
            ALU_ADD: r = a + b;
            ALU_SUB: r = a - b;
            ALU_AND: r = a & b;
            ALU_OR: r = a | b;
            ALU_XOR: r = a ^ b;
            ALU_PASS: r = a;
            default: r = a * b;
        endcase
        return (f == FMT_EXTENDED) ? r : (r & 40'hffffffff);
    endfunction

    function automatic logic [39:0] shf(input logic [1:0] o, input logic [1:0] f, input logic [39:0] a, b);
        logic [39:0] r;
        case (o)
            SHF_LSL: r = a << b[4:0];
            SHF_LSR: r = a >> b[4:0];
            default: r = 40'($signed(a) >>> b[4:0]);
        endcase
        return (f == FMT_EXTENDED) ? r : (r & 40'hffffffff);
    endfunction

    function automatic logic [63:0] wr(input logic b, input logic [3:0] r);
        return {mode[0] ? ry[b][r][31:0] : 32'h0, rx[b][r][31:0]};
    endfunction

    function automatic logic [31:0] nx(input int d, input logic g, input logic [3:0] s);
        logic [31:0] n;
        n = pt[d][g][s] + sp[d][g][s];
        return (n >= bs[d][g][s] + ln[d][g][s]) ? n - ln[d][g][s] : n;
    endfunction

    task automatic setr(input logic b, input logic [3:0] r, input logic [39:0] x, y);
        rx[b][r] = x;
        if (mode[0])
            ry[b][r] = y;
    endtask

    task automatic run(input logic [47:0] i);
        logic go, de, pe, ms, b, gd, gp, ac;
        logic [31:0] ad, ap, a;
        logic [63:0] vd, vp;
        logic [39:0] ex, ey, mx, my;
        a = 32'(pc);
        pc++;
        @(negedge clk);
        sdc_mem_model_i.im[a[7:0]] = i;
        fa = a;
        fv = 1;
        cf = ncf;
        #20;
        ms = ppm && !(cv[a[4:0]] && ct[a[4:0]] === a);
        cmp_bus(64'(stl), 64'(ms));
        if (ms)
        begin
            cv[a[4:0]] = 1;
            ct[a[4:0]] = a;
            @(negedge clk);
            #20;
            cmp_bus(64'(stl), 64'h0);
        end
        go = !i[47] || i[46] === cf;
        de = go && i[21];
        pe = go && i[11];
        b = mode[1];
        gd = mode[2];
        gp = mode[3];
        ad = pt[0][gd][i[15:12]];
        ap = pt[1][gp][i[5:2]];
        vd = sdc_mem_model_i.dm[ad[7:0]];
        vp = sdc_mem_model_i.pm[ap[7:0]];
        cmp_bus(64'({dr, dw, pr, pw}), 64'({de, de && i[20], pe, pe && i[10]}));
        if (de) cmp_bus(64'(da), 64'(ad));
        if (pe) cmp_bus(64'(pa), 64'(ap));
        if (de && i[20]) cmp_bus(dwd, wr(b, i[19:16]));
        if (pe && i[10]) cmp_bus(pwd, wr(b, i[9:6]));
        ex = alu(i[43:41], i[45:44], rx[b][i[33:30]], rx[b][i[29:26]]);
        ey = alu(i[43:41], i[45:44], ry[b][i[33:30]], ry[b][i[29:26]]);
        mx = alu(ALU_NOP, i[45:44], rx[b][i[33:30]], rx[b][i[29:26]]);
        my = alu(ALU_NOP, i[45:44], ry[b][i[33:30]], ry[b][i[29:26]]);
        // the shifter answers only when the alu is idle
        ac = i[43:41] != ALU_NOP || i[39:38] != SHF_NOP;
        if (i[43:41] == ALU_NOP && i[39:38] != SHF_NOP)
        begin
            ex = shf(i[39:38], i[45:44], rx[b][i[33:30]], rx[b][i[29:26]]);
            ey = shf(i[39:38], i[45:44], ry[b][i[33:30]], ry[b][i[29:26]]);
        end
        // later writers win: memory load over multiply over alu
        if (go && ac) setr(b, i[37:34], ex, ey);
        if (go && i[40]) setr(b, i[25:22], mx, my);
        if (de && !i[20]) setr(b, i[19:16], 40'(vd[31:0]), 40'(vd[63:32]));
        if (pe && !i[10]) setr(b, i[9:6], 40'(vp[31:0]), 40'(vp[63:32]));
        if (de) pt[0][gd][i[15:12]] = nx(0, gd, i[15:12]);
        if (pe) pt[1][gp][i[5:2]] = nx(1, gp, i[5:2]);
        ppm = pe;
        @(posedge clk);
        #1;
        cmp_bus(64'(rv), 64'(go));
        if (go && ac)
        begin
            cmp_res(rxo, ex);
            if (mode[0]) cmp_res(ryo, ey);
            lx = ex;
        end
        if (!go) cmp_res(rxo, lx);
    endtask

    task automatic idle(input logic [3:0] m);
        @(negedge clk);
        fv = 0;
        mode = m;
        ppm = 0;
    endtask

    task automatic ld(input logic s, input logic [3:0] n, input logic [31:0] b0, l0, s0);
        logic g;
        @(negedge clk);
        fv = 0;
        {dl, dsel, dset, db, dln, dst} = {1'b1, s, n, b0, l0, s0};
        g = s ? mode[3] : mode[2];
        bs[s][g][n] = b0;
        ln[s][g][n] = l0;
        sp[s][g][n] = s0;
        pt[s][g][n] = b0;
        @(negedge clk);
        dl = 0;
        ppm = 0;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1500)
        begin
            fail_count++;
            wrap_up();
        end
    end

    initial
    begin
        {fv, dl, dsel, cf, ncf, ppm, mode, dset, fa, db, dln, dst, lx} = '0;
        seed = 32'h1785;
        for (int k = 0; k < 256; k++)
        begin
            sdc_mem_model_i.dm[k] = {xs(), xs()};
            sdc_mem_model_i.pm[k] = {xs(), xs()};
        end
        for (int k = 0; k < 32; k++)
        begin
            cv[k] = 0;
            rx[k[4]][k[3:0]] = 0;
            ry[k[4]][k[3:0]] = 0;
        end
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 0;
        idle(4'h1);
        ld(0, 0, 32'h10, 32'h40, 32'h1);
        ld(1, 0, 32'h20, 32'h40, 32'h1);
        // second pass meets the cached fetches, its first fetch was never cached
        repeat (2)
        begin
            pc = 0;
            for (int k = 0; k < 8; k++)
                run(mm(10'h200 | 10'(k) << 4, 10'h280 | 10'(k) << 4));
        end
        pc = 16;
        for (int o = 1; o < 8; o++)
            if (o != 3) run(op(3'(o), FMT_FIXED, 4'(o + 8), 4'(xs()), 4'(xs())));
        for (int s = 1; s < 4; s++)
            run(op(ALU_NOP, FMT_FIXED, 4'd10, 4'(xs()), 4'(xs())) | 48'(s) << F_SHF_LO);
        for (int f = 0; f < 3; f++)
            run(op(ALU_ADD, 2'(f), 4'd12, 4'd0, 4'd1));
        run(op(ALU_SUB, FMT_FIXED, 4'd13, 4'd2, 4'd3) | 48'h1 << F_MUL_EN | 48'(14) << F_MDST_LO);
        run(op(ALU_XOR, FMT_FIXED, 4'd9, 4'd4, 4'd5) | 48'h3 << F_COND_FLAG);
        ncf = 1;
        run(op(ALU_XOR, FMT_FIXED, 4'd9, 4'd4, 4'd5) | 48'h3 << F_COND_FLAG);
        ncf = 0;
        run(mm(10'h3e0, 10'h3e0));
        idle(4'h3);
        run(mm(10'h200, 10'h0));
        run(mm(10'h300, 10'h0));
        idle(4'h1);
        run(mm(10'h300, 10'h0));
        idle(4'h0);
        run(mm(10'h310, 10'h0));
        run(op(ALU_ADD, FMT_FIXED, 4'd11, 4'd2, 4'd3));
        idle(4'h1);
        ld(0, 2, 32'h83, 32'h3, 32'h1);
        ld(1, 3, 32'hc1, 32'h2, 32'h1);
        idle(4'h9);
        ld(1, 3, 32'h51, 32'h5, 32'h2);
        repeat (4) run(mm(10'h262, 10'h273));
        idle(4'h1);
        repeat (3) run(mm(10'h0, 10'h273));
        idle(4'h1);
        wrap_up();
    end
endmodule
